//--- mct_timer.sv
// How it works
// RULE_01: four timers, each with 32-bit counter
// RULE_02: counts peripheral clock or external clock edges
// RULE_03: software selects timer or counter mode
// RULE_04: 32-bit prescaler divides source before counter
// RULE_05: four 32-bit match values compared continuously; a match only registers on a running prescaler step here
// RULE_06: match may let count run, optional interrupt
// RULE_07: match may halt counter, optional interrupt
// RULE_08: match may zero counter, optional interrupt
// RULE_09: match pin low, high, toggle or unchanged
// RULE_10: capture copies counter on input transition
// RULE_11: capture interrupt enabled per channel
// RULE_12: event flags stay set until software clears
`timescale 1ns/1ps
module mct_timer import mct_pkg::*; #(
  parameter int NUM_TIMERS = 4,
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [MCT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // pins, four per timer
  input wire logic [NUM_TIMERS*MCT_CHANNELS-1:0] capPin,
  output logic [NUM_TIMERS*MCT_CHANNELS-1:0] matchPin,
  // per-timer pending event indication
  output logic [NUM_TIMERS-1:0] tmrIrq
);

  localparam int NCH = MCT_CHANNELS;
  localparam int NPIN = NUM_TIMERS * MCT_CHANNELS;

  if (NUM_TIMERS < 1 || NUM_TIMERS > MCT_MAX_TIMERS) begin : g_bad_timers
    $error("NUM_TIMERS must be 1 to 4");
  end
  if (CNT_W != 32) begin : g_bad_width
    $error("CNT_W must be 32");
  end

  function automatic logic [6:0] wordOff(input logic [6:0] base, input int idx);
    wordOff = base + 7'(idx) * WORD_STEP;
  endfunction

  function automatic logic [31:0] pad(input logic [11:0] v);
    pad = {20'h0, v};
  endfunction

  // apb decode
  wire [6:0] offs = paddr[MCT_OFF_W-1:0];
  wire [1:0] tsel = paddr[MCT_TSEL_MSB:MCT_TSEL_LSB];
  wire addrOk = (32'(tsel) < NUM_TIMERS) && (offs <= OFF_LAST) && (offs[1:0] == 2'h0);
  wire apbSetup = psel & ~penable;
  wire apbWrite = psel & penable & pwrite & addrOk;

  logic [31:0] rdT [NUM_TIMERS];
  logic [31:0] prdataQ;
  logic slvErrQ;

  // external pins, filtered once for all timers
  logic [NPIN-1:0] capLevel, capRise, capFall;

  mct_sync #(.WIDTH(NPIN)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pinIn(capPin),
    .level(capLevel),
    .rise(capRise),
    .fall(capFall)
  );

  for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr // RULE_01
    logic [CTRL_W-1:0] ctrlQ, ctrlD;
    logic [CNT_W-1:0] countQ, countD;
    logic [CNT_W-1:0] preQ;
    logic [CNT_W-1:0] preCntQ, preCntD;
    logic [NCH*FLD3-1:0] mctlQ;
    logic [NCH*FLD3-1:0] cctlQ;
    logic [MODE_W-1:0] modeQ;
    logic [EXT_W-EXT_ACT_LSB-1:0] actQ;
    logic [STAT_W-1:0] statQ, statD;
    logic [CNT_W-1:0] matchQ [NCH];
    logic [CNT_W-1:0] capQ [NCH];
    logic [NCH-1:0] hit, pinLvl, mIntEn, mRstEn, mStopEn, capEvt, capIntEn;

    wire tHere = (tsel == 2'(g));
    wire wrOk = apbWrite & tHere;
    wire wrStat = wrOk & (offs == OFF_STAT);
    wire wrCtrl = wrOk & (offs == OFF_CTRL);
    wire wrCount = wrOk & (offs == OFF_COUNT);
    wire wrPre = wrOk & (offs == OFF_PRE);
    wire wrPreCnt = wrOk & (offs == OFF_PRECNT);
    wire wrMctl = wrOk & (offs == OFF_MCTL);
    wire wrCctl = wrOk & (offs == OFF_CCTL);
    wire wrMode = wrOk & (offs == OFF_MODE);
    wire wrExt = wrOk & (offs == OFF_EXT);

    // count source: every clock, or an edge of the selected capture pin
    wire [1:0] srcSel = modeQ[MODE_SRC_LSB +: 2];
    wire [1:0] pinSel = modeQ[MODE_SEL_LSB +: 2];
    wire extRise = capRise[g*NCH + 32'(pinSel)];
    wire extFall = capFall[g*NCH + 32'(pinSel)];
    wire tick = (srcSel == MCT_SRC_TIMER) ? 1'b1 : // RULE_02 RULE_03
                (srcSel == MCT_SRC_RISE) ? extRise :
                (srcSel == MCT_SRC_FALL) ? extFall : (extRise | extFall);

    wire running = ctrlQ[CTRL_EN] & ~ctrlQ[CTRL_RST];
    wire preWrap = running & tick & (preCntQ == preQ); // RULE_04
    wire anyReset = |(hit & mRstEn); // RULE_08
    wire anyStop = |(hit & mStopEn); // RULE_07

    for (genvar c = 0; c < NCH; c++) begin : g_ch
      wire wrMatch = wrOk & (offs == wordOff(OFF_MATCH0, c));
      assign mIntEn[c] = mctlQ[c*FLD3 + MCTL_INT];
      assign mRstEn[c] = mctlQ[c*FLD3 + MCTL_RESET];
      assign mStopEn[c] = mctlQ[c*FLD3 + MCTL_STOP];
      assign capIntEn[c] = cctlQ[c*FLD3 + CCTL_INT];
      // RULE_10
      assign capEvt[c] = (capRise[g*NCH + c] & cctlQ[c*FLD3 + CCTL_RISE]) |
                         (capFall[g*NCH + c] & cctlQ[c*FLD3 + CCTL_FALL]);

      mct_match #(.CNT_W(CNT_W)) u_match (
        .mclk(mclk),
        .reset_n(reset_n),
        .count(countQ),
        .matchVal(matchQ[c]),
        .advance(preWrap),
        .action(actQ[c*2 +: 2]),
        .swWrite(wrExt),
        .swLevel(pwdata[c]),
        .hit(hit[c]), // RULE_05
        .pinLevel(pinLvl[c]) // RULE_09
      );

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          matchQ[c] <= '0;
          capQ[c] <= '0;
        end else begin
          if (wrMatch) begin
            matchQ[c] <= pwdata;
          end
          if (capEvt[c]) begin
            capQ[c] <= countQ; // RULE_10
          end
        end
      end
    end

    // counter: hold in reset, software load, match zero, then step
    always_comb begin
      countD = countQ;
      if (ctrlQ[CTRL_RST]) begin
        countD = '0;
      end else if (wrCount) begin
        countD = pwdata;
      end else if (anyReset) begin
        countD = '0; // RULE_08
      end else if (preWrap) begin
        countD = countQ + 1'b1; // RULE_06
      end
    end

    always_comb begin
      preCntD = preCntQ;
      if (ctrlQ[CTRL_RST]) begin
        preCntD = '0;
      end else if (wrPreCnt) begin
        preCntD = pwdata;
      end else if (running & tick) begin
        preCntD = preWrap ? '0 : preCntQ + 1'b1; // RULE_04
      end
    end

    // stop on match overrides a write in the same cycle
    always_comb begin
      ctrlD = wrCtrl ? pwdata[CTRL_W-1:0] : ctrlQ;
      if (anyStop) begin
        ctrlD[CTRL_EN] = 1'b0; // RULE_07
      end
    end

    // write one to clear; a new event in the same cycle wins
    assign statD = (statQ & ~(wrStat ? pwdata[STAT_W-1:0] : '0)) |
                   {capEvt & capIntEn, hit & mIntEn}; // RULE_06 RULE_11 RULE_12

    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        ctrlQ <= '0;
        countQ <= '0;
        preCntQ <= '0;
        statQ <= '0;
      end else begin
        ctrlQ <= ctrlD;
        countQ <= countD;
        preCntQ <= preCntD;
        statQ <= statD; // RULE_12
      end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        preQ <= '0;
        mctlQ <= '0;
        cctlQ <= '0;
        modeQ <= '0;
        actQ <= '0;
      end else begin
        if (wrPre) preQ <= pwdata;
        if (wrMctl) mctlQ <= pwdata[NCH*FLD3-1:0];
        if (wrCctl) cctlQ <= pwdata[NCH*FLD3-1:0];
        if (wrMode) modeQ <= pwdata[MODE_W-1:0];
        if (wrExt) actQ <= pwdata[EXT_W-1:EXT_ACT_LSB];
      end
    end

    // read mux for this bank
    wire [1:0] wIdx = 2'((offs - OFF_MATCH0) >> 2);
    wire [1:0] cIdx = 2'((offs - OFF_CAP0) >> 2);
    wire inMatch = (offs >= OFF_MATCH0) && (offs < OFF_CCTL);
    wire inCap = (offs >= OFF_CAP0) && (offs < OFF_MODE);
    assign rdT[g] = (offs == OFF_STAT) ? {24'h0, statQ} :
                    (offs == OFF_CTRL) ? {30'h0, ctrlQ} :
                    (offs == OFF_COUNT) ? countQ :
                    (offs == OFF_PRE) ? preQ :
                    (offs == OFF_PRECNT) ? preCntQ :
                    (offs == OFF_MCTL) ? pad(mctlQ) :
                    (offs == OFF_CCTL) ? pad(cctlQ) :
                    (offs == OFF_MODE) ? {28'h0, modeQ} :
                    (offs == OFF_EXT) ? pad({actQ, pinLvl}) :
                    inMatch ? matchQ[wIdx] :
                    inCap ? capQ[cIdx] : 32'h0;

    assign matchPin[g*NCH +: NCH] = pinLvl; // RULE_09
    assign tmrIrq[g] = |statQ; // RULE_11
  end

  // read data and error are latched in the setup cycle, zero wait access
  wire [31:0] rdSel = addrOk ? rdT[32'(tsel) % NUM_TIMERS] : 32'h0;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdataQ <= 32'h0;
      slvErrQ <= 1'b0;
    end else if (apbSetup) begin
      prdataQ <= pwrite ? 32'h0 : rdSel;
      slvErrQ <= ~addrOk;
    end
  end

  assign pready = 1'b1;
  assign prdata = prdataQ;
  assign pslverr = slvErrQ;

endmodule

//--- mct_pkg.sv
package mct_pkg;

  // register bank layout, one bank per timer
  localparam int MCT_MAX_TIMERS = 4;
  localparam int MCT_CHANNELS = 4;
  localparam int MCT_ADDR_W = 9;
  localparam int MCT_TSEL_LSB = 7;
  localparam int MCT_TSEL_MSB = 8;
  localparam int MCT_OFF_W = 7;

  localparam logic [6:0] OFF_STAT = 7'h00;
  localparam logic [6:0] OFF_CTRL = 7'h04;
  localparam logic [6:0] OFF_COUNT = 7'h08;
  localparam logic [6:0] OFF_PRE = 7'h0C;
  localparam logic [6:0] OFF_PRECNT = 7'h10;
  localparam logic [6:0] OFF_MCTL = 7'h14;
  localparam logic [6:0] OFF_MATCH0 = 7'h18;
  localparam logic [6:0] OFF_CCTL = 7'h28;
  localparam logic [6:0] OFF_CAP0 = 7'h2C;
  localparam logic [6:0] OFF_MODE = 7'h3C;
  localparam logic [6:0] OFF_EXT = 7'h40;
  localparam logic [6:0] OFF_LAST = 7'h40;
  localparam logic [6:0] WORD_STEP = 7'h04;

  // control bits
  localparam int CTRL_EN = 0;
  localparam int CTRL_RST = 1;
  localparam int CTRL_W = 2;
  // match control: three bits per channel
  localparam int MCTL_INT = 0;
  localparam int MCTL_RESET = 1;
  localparam int MCTL_STOP = 2;
  localparam int FLD3 = 3;
  // capture control: three bits per channel
  localparam int CCTL_RISE = 0;
  localparam int CCTL_FALL = 1;
  localparam int CCTL_INT = 2;
  // mode register
  localparam int MODE_SRC_LSB = 0;
  localparam int MODE_SEL_LSB = 2;
  localparam int MODE_W = 4;
  // external match register: levels low, actions above
  localparam int EXT_ACT_LSB = 4;
  localparam int EXT_W = 12;
  // status register: match flags low, capture flags high
  localparam int STAT_W = 8;

  typedef enum logic [1:0] {
    MCT_SRC_TIMER = 2'h0,
    MCT_SRC_RISE = 2'h1,
    MCT_SRC_FALL = 2'h2,
    MCT_SRC_BOTH = 2'h3
  } mct_src_t;

  typedef enum logic [1:0] {
    MCT_ACT_NONE = 2'h0,
    MCT_ACT_LOW = 2'h1,
    MCT_ACT_HIGH = 2'h2,
    MCT_ACT_TOGGLE = 2'h3
  } mct_act_t;

endpackage

//--- mct_sync.sv
`timescale 1ns/1ps
module mct_sync import mct_pkg::*; #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // asynchronous pins
  input wire logic [WIDTH-1:0] pinIn,
  // filtered level and edge pulses
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] s1Q, s2Q, s3Q, levelQ, riseQ, fallQ;
  wire [WIDTH-1:0] agree = ~(s2Q ^ s3Q);
  // level only moves once the two late stages agree
  wire [WIDTH-1:0] levelD = (agree & s3Q) | (~agree & levelQ);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1Q <= '0;
      s2Q <= '0;
      s3Q <= '0;
      levelQ <= '0;
      riseQ <= '0;
      fallQ <= '0;
    end else begin
      s1Q <= pinIn;
      s2Q <= s1Q;
      s3Q <= s2Q;
      levelQ <= levelD;
      riseQ <= levelD & ~levelQ;
      fallQ <= ~levelD & levelQ;
    end
  end

  assign level = levelQ;
  assign rise = riseQ;
  assign fall = fallQ;

endmodule

//--- mct_match.sv
`timescale 1ns/1ps
module mct_match import mct_pkg::*; #(
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // compare
  input wire logic [CNT_W-1:0] count,
  input wire logic [CNT_W-1:0] matchVal,
  input wire logic advance,
  // external output control
  input wire logic [1:0] action,
  input wire logic swWrite,
  input wire logic swLevel,
  // results
  output logic hit,
  output logic pinLevel
);

  logic levelQ;
  logic levelD;

  // only a counting step can hit, so a halted count never refires
  assign hit = advance & (count == matchVal);

  always_comb begin
    levelD = levelQ;
    if (swWrite) begin
      levelD = swLevel;
    end
    if (hit) begin
      case (mct_act_t'(action))
        MCT_ACT_LOW: levelD = 1'b0;
        MCT_ACT_HIGH: levelD = 1'b1;
        MCT_ACT_TOGGLE: levelD = ~levelQ;
        default: levelD = levelQ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      levelQ <= 1'b0;
    end else begin
      levelQ <= levelD;
    end
  end

  assign pinLevel = levelQ;

endmodule

//--- mct_timer_sva.sv
`timescale 1ns/1ps
module mct_timer_sva import mct_pkg::*; #(
  parameter int NUM_TIMERS = 4,
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [MCT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // pins and events
  input wire logic [NUM_TIMERS*MCT_CHANNELS-1:0] capPin,
  input wire logic [NUM_TIMERS*MCT_CHANNELS-1:0] matchPin,
  input wire logic [NUM_TIMERS-1:0] tmrIrq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire setup = psel && !penable;
  wire acc = psel && penable && pwrite;
  wire statWr0 = acc && paddr == 9'h000;
  wire statWr1 = acc && paddr == 9'h080;
  // timer 2 has no pin actions and timer 3 never runs, so only software moves their pins
  wire extWr2 = acc && paddr == 9'h140;
  wire extWr3 = acc && paddr == 9'h1C0;
  property p_irq0_hold; tmrIrq[0] && !statWr0 |=> tmrIrq[0]; endproperty
  a_irq0_hold: assert property (p_irq0_hold) else $error("timer 0 flag dropped");
  property p_irq1_hold; tmrIrq[1] && !statWr1 |=> tmrIrq[1]; endproperty
  a_irq1_hold: assert property (p_irq1_hold) else $error("timer 1 flag dropped");
  property p_ext_level; extWr3 |=> matchPin[15:12] == $past(pwdata[3:0]); endproperty
  a_ext_level: assert property (p_ext_level) else $error("pin level write lost");
  property p_pin_hold; !extWr2 |=> $stable(matchPin[11:8]); endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin moved without action");
  property p_err_align; setup && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0; endproperty
  a_err_align: assert property (p_err_align) else $error("unaligned access accepted");
  property p_err_range; setup && paddr[6:0] > OFF_LAST |=> pslverr; endproperty
  a_err_range: assert property (p_err_range) else $error("unmapped offset accepted");
  property p_ok_map; setup && paddr[1:0] == 2'h0 && paddr[6:0] <= OFF_LAST |=> !pslverr; endproperty
  a_ok_map: assert property (p_ok_map) else $error("mapped access refused");
  property p_err_hold; pslverr && !setup |=> pslverr && pready; endproperty
  a_err_hold: assert property (p_err_hold) else $error("error response dropped early");
  c_irq: cover property (tmrIrq[0] && tmrIrq[1]);
  c_toggle: cover property (matchPin[4] != $past(matchPin[4]));
  c_err: cover property (setup && paddr[6:0] > OFF_LAST);
endmodule

bind mct_timer mct_timer_sva #(.NUM_TIMERS(NUM_TIMERS), .CNT_W(CNT_W)) mct_timer_sva_i (.mclk(mclk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .capPin(capPin), .matchPin(matchPin), .tmrIrq(tmrIrq));

//--- mct_pin_model.sv
`timescale 1ns/1ps
module mct_pin_model (
  // clock
  input wire logic mclk,
  // capture and count pins
  output logic [15:0] capPin
);
  initial capPin = 16'h0000;
  // six cycles each side so the synchroniser sees every level
  task pulse(input int idx, input int cnt);
    repeat (cnt) begin
      @(posedge mclk);
      capPin[idx] <= 1'b1;
      repeat (6) @(posedge mclk);
      capPin[idx] <= 1'b0;
      repeat (6) @(posedge mclk);
    end
  endtask
endmodule

//--- mct_timer_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module mct_timer_tb import mct_pkg::*;;
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, ev;
  logic [8:0] paddr;
  logic [31:0] pwdata, prdata, rv, c0;
  logic [15:0] capPin, matchPin;
  logic [3:0] tmrIrq;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  // ext writes: drive low from high, high from low, none from low
  localparam logic [31:0] EXT_SEQ [3] = '{32'h11, 32'h20, 32'h00};
  localparam logic EXP_PIN [3] = '{1'b0, 1'b1, 1'b0};
  mct_timer #(.NUM_TIMERS(4), .CNT_W(32)) mct_timer_i (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .capPin(capPin), .matchPin(matchPin), .tmrIrq(tmrIrq));
  mct_pin_model mct_pin_model_i (.mclk(mclk), .capPin(capPin));
  function automatic int ad(input int t, input int off);
    return t * 128 + off;
  endfunction
  task automatic xfer(input logic w, input int a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= 9'(a); pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 50);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic waitpin(input int b);
    logic v;
    v = matchPin[b];
    n = 0;
    do begin @(negedge mclk); n++; end while (matchPin[b] === v && n < 100);
  endtask
  task complete_run;
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin errors++; complete_run; end
  end
  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 9'h000; pwdata = 32'h0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    xfer(0, ad(0, OFF_COUNT), 32'h0); `CHK(rv, 32'h0)
    xfer(1, ad(3, OFF_CAP0), 32'hFFFFFFFF); xfer(0, ad(3, OFF_CAP0), 32'h0); `CHK(rv, 32'h0)
    xfer(0, ad(3, 32'h44), 32'h0); `CHK(ev, 1'b1)
    xfer(0, ad(0, 32'h06), 32'h0); `CHK(ev, 1'b1)
    for (int i = 0; i < 4; i++) xfer(1, ad(3, OFF_MATCH0 + 4 * i), 32'hA5000000 + i);
    for (int i = 0; i < 4; i++) begin
      xfer(0, ad(3, OFF_MATCH0 + 4 * i), 32'h0); `CHK(rv, 32'hA5000000 + i)
    end
    xfer(1, ad(3, OFF_EXT), 32'h5); @(negedge mclk); `CHK(matchPin[15:12], 4'h5)
    // stop on match with flag, timer 0
    xfer(1, ad(0, OFF_PRE), 32'h2); xfer(1, ad(0, OFF_MATCH0), 32'h5);
    xfer(1, ad(0, OFF_MCTL), 32'h5); xfer(1, ad(0, OFF_CTRL), 32'h1);
    n = 0;
    while (tmrIrq[0] !== 1'b1 && n < 100) begin @(posedge mclk); n++; end
    xfer(0, ad(0, OFF_CTRL), 32'h0); `CHK(rv[0], 1'b0)
    xfer(0, ad(0, OFF_COUNT), 32'h0); c0 = rv; repeat (10) @(posedge mclk);
    xfer(0, ad(0, OFF_COUNT), 32'h0); `CHK(rv, c0)
    xfer(0, ad(0, OFF_STAT), 32'h0); `CHK(rv, 32'h1)
    xfer(1, ad(0, OFF_STAT), 32'h1); xfer(0, ad(0, OFF_STAT), 32'h0); `CHK(rv, 32'h0)
    `CHK(tmrIrq[0], 1'b0)
    // capture on rising edge, channel 1
    xfer(1, ad(0, OFF_MCTL), 32'h0); xfer(1, ad(0, OFF_CTRL), 32'h2); xfer(1, ad(0, OFF_CTRL), 32'h1);
    xfer(1, ad(0, OFF_CCTL), 32'h28); xfer(0, ad(0, OFF_COUNT), 32'h0); c0 = rv;
    mct_pin_model_i.pulse(1, 1);
    xfer(0, ad(0, OFF_CAP0 + 4), 32'h0); `CHK(rv > c0 && rv < c0 + 32'h28, 1'b1)
    xfer(0, ad(0, OFF_STAT), 32'h0); `CHK(rv, 32'h20)
    // counter mode on pin edges, prescale by two
    xfer(1, ad(2, OFF_PRE), 32'h1); xfer(1, ad(2, OFF_MODE), 32'h1);
    xfer(1, ad(2, OFF_CTRL), 32'h1);
    mct_pin_model_i.pulse(8, 6); repeat (10) @(posedge mclk);
    xfer(0, ad(2, OFF_COUNT), 32'h0); `CHK(rv, 32'h3)
    xfer(0, ad(2, OFF_PRECNT), 32'h0); `CHK(rv, 32'h0)
    // both edges, then falling edges only, still prescaled by two
    xfer(1, ad(2, OFF_CTRL), 32'h2); xfer(1, ad(2, OFF_MODE), 32'h3); xfer(1, ad(2, OFF_CTRL), 32'h1);
    mct_pin_model_i.pulse(8, 2); repeat (10) @(posedge mclk);
    xfer(0, ad(2, OFF_COUNT), 32'h0); `CHK(rv, 32'h2)
    xfer(1, ad(2, OFF_CTRL), 32'h2); xfer(1, ad(2, OFF_MODE), 32'h2); xfer(1, ad(2, OFF_CTRL), 32'h1);
    mct_pin_model_i.pulse(8, 4); repeat (10) @(posedge mclk);
    xfer(0, ad(2, OFF_COUNT), 32'h0); `CHK(rv, 32'h2)
    // reset on match, period four, pin actions
    xfer(1, ad(1, OFF_MATCH0), 32'h3); xfer(1, ad(1, OFF_MCTL), 32'h2); xfer(1, ad(1, OFF_CTRL), 32'h1);
    for (int i = 0; i < 3; i++) begin
      xfer(1, ad(1, OFF_EXT), EXT_SEQ[i]); repeat (10) @(negedge mclk);
      `CHK(matchPin[4], EXP_PIN[i])
    end
    xfer(1, ad(1, OFF_EXT), 32'h30); @(negedge mclk); waitpin(4); waitpin(4); `CHK(n, 4)
    xfer(0, ad(1, OFF_COUNT), 32'h0); `CHK(rv <= 32'h3, 1'b1)
    xfer(0, ad(1, OFF_STAT), 32'h0); `CHK(rv, 32'h0)
    xfer(1, ad(1, OFF_MCTL), 32'h3); repeat (10) @(posedge mclk);
    xfer(0, ad(1, OFF_STAT), 32'h0); `CHK(rv, 32'h1)
    `CHK(tmrIrq[1], 1'b1)
    xfer(0, ad(1, OFF_CTRL), 32'h0); `CHK(rv[0], 1'b1)
    complete_run;
  end
endmodule
